// ---- hw/mdr_pkg.sv ----
// shared constants and types for the microcode download and restart block
package mdr_pkg;
	localparam logic [7:0] MDR_LOAD_OFFSET    = 8'h7E;
	localparam logic [7:0] MDR_RESTART_OFFSET = 8'h7F;
	localparam int         MDR_MEM_DEPTH      = 5120;
	localparam int         MDR_WORD_W         = 20;
	localparam int         MDR_ADDR_W         = 13;
	localparam int         MDR_HI_NIBBLE_W    = 4;
	localparam logic [12:0] MDR_PTR_RESET     = 13'h0000;
	localparam int         MDR_INIT_TIME_US   = 5000;
	localparam int         MDR_CLK_MHZ        = 25;
	localparam int         MDR_INIT_CYCLES    = MDR_INIT_TIME_US * MDR_CLK_MHZ;
	localparam int         MDR_CNT_W          = 17;

	typedef enum logic [1:0] {
		MDR_RUN,
		MDR_LOAD,
		MDR_INIT
	} mdr_state_t;

	// one register access from the host port front end
	typedef struct packed {
		logic       valid;
		logic       write;
		logic [7:0] addr;
		logic [7:0] data;
	} mdr_access_t;

	// one word into the instruction memory
	typedef struct packed {
		logic                  en;
		logic [MDR_ADDR_W-1:0] addr;
		logic [MDR_WORD_W-1:0] data;
	} mdr_mem_wr_t;
endpackage

// ---- hw/mdr_imem.sv ----
// instruction memory, one write port and one registered read port
`timescale 1ns/1ps
module mdr_imem
	import mdr_pkg::*;
(
	input  wire logic                  clk,
	input  wire mdr_mem_wr_t           wr,
	input  wire logic [MDR_ADDR_W-1:0] rd_addr,
	output logic      [MDR_WORD_W-1:0] rd_data
);
	logic [MDR_WORD_W-1:0] mem [MDR_MEM_DEPTH];

	// storage has no reset; content is lost at power-down anyway
	always_ff @(posedge clk) begin
		if (wr.en) begin
			mem[wr.addr] <= wr.data;
		end
		rd_data <= mem[rd_addr];
	end
endmodule

// ---- hw/mdr_loader.sv ----
// microcode download engine, processor halt control and restart wait
// Functional notes
// R1 - host waits at least four pixel clocks after reset before loading
// R2 - host waits longer when the device was never initialised before
// R3 - a write to 7Eh halts processor and arms the memory for loading; a write during MDR_INIT is ignored
// R4 - load bytes fill consecutive ascending memory locations from the first
// R5 - each 20-bit word arrives as three bytes, most significant first
// R6 - upper four bits of the first byte are dropped
// R7 - host may split the load into blocks touching only 7Eh between
// R8 - any other register access zeroes the pointer and resumes the processor
// R9 - a write to 7Fh wakes the processor and resumes normal operation
// R10 - processor initialisation takes up to 5 ms before host setup
// R11 - instruction memory is 5K words of 20 bits
// R12 - host reloads the full microcode at every power-up
// R13 - serial clock is held low until initialisation ends; held only when restart_via_serial was set at the 7Fh write
// R14 - video port accesses are slave-terminated until initialisation ends
// R15 - parallel host may use interrupt request or poll status for readiness
// R16 - pointer advances only after the third byte is stored
`timescale 1ns/1ps
module mdr_loader
	import mdr_pkg::*;
#(
	parameter int INIT_CYCLES = MDR_INIT_CYCLES
)
(
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire mdr_access_t           acc,
	input  wire logic                  restart_via_serial,
	input  wire logic [MDR_ADDR_W-1:0] cpu_fetch_addr,
	output logic      [MDR_WORD_W-1:0] cpu_fetch_data,
	output logic                       cpu_halt,
	output logic                       init_busy,
	output logic                       serial_clk_hold_low,
	output logic                       vip_terminate,
	output logic                       host_interrupt_request,
	output logic      [MDR_ADDR_W-1:0] load_pointer
);
	mdr_state_t            state;
	mdr_state_t            next_state;
	logic [MDR_ADDR_W-1:0] ptr;
	logic [MDR_ADDR_W-1:0] next_ptr;
	logic [1:0]            byte_idx;
	logic [1:0]            next_byte_idx;
	logic [15:0]           hold;
	logic [15:0]           next_hold;
	logic [MDR_CNT_W-1:0]  cnt;
	logic [MDR_CNT_W-1:0]  next_cnt;
	logic                  serial_rs;
	logic                  next_serial_rs;
	logic                  irq;
	logic                  next_irq;
	mdr_mem_wr_t           wr;
	logic                  load_hit;
	logic                  restart_hit;
	logic                  abort_hit;
	logic                  init_done;

	// true for a write that lands on the given register
	function automatic logic hit(input mdr_access_t a, input logic [7:0] o);
		hit = a.valid && a.write && (a.addr == o);
	endfunction

	// any access, read or write, to a register outside the load register, except a write to the restart register
	function automatic logic other(input mdr_access_t a);
		other = a.valid && (a.addr != MDR_LOAD_OFFSET)
			&& !(a.write && (a.addr == MDR_RESTART_OFFSET));
	endfunction

	// decoded view of the access on this edge
	assign load_hit    = hit(acc, MDR_LOAD_OFFSET);
	assign restart_hit = hit(acc, MDR_RESTART_OFFSET);
	assign abort_hit   = other(acc);
	// timer at zero ends the wait on the next edge
	assign init_done   = (state == MDR_INIT) && (cnt == '0);

	// next state of the download sequencer
	always_comb begin
		next_state = state;
		unique case (state)
			MDR_RUN: begin
				// R3 halt on load
				if (load_hit) begin
					next_state = MDR_LOAD;
				end
			end
			MDR_LOAD: begin
				if (restart_hit) begin
					// R9 wake on restart
					next_state = MDR_INIT;
				end else if (abort_hit) begin
					// R8 processor resumes
					next_state = MDR_RUN;
				end
			end
			MDR_INIT: begin
				// R10 init wait
				if (init_done) begin
					next_state = MDR_RUN;
				end
			end
			default: begin
				next_state = MDR_RUN;
			end
		endcase
	end

	// sequencer state register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= MDR_RUN;
		end else begin
			state <= next_state;
		end
	end

	// next values of the word assembly and the write pointer
	always_comb begin
		next_ptr      = ptr;
		next_byte_idx = byte_idx;
		next_hold     = hold;
		wr.en         = 1'b0;
		wr.addr       = ptr;
		// R6 drop top nibble
		wr.data       = {hold[11:0], acc.data};
		if (state == MDR_RUN && load_hit) begin
			// R4 start at zero
			next_hold     = {8'h00, acc.data};
			next_byte_idx = 2'd1;
			next_ptr      = MDR_PTR_RESET;
		end else if (state == MDR_LOAD && load_hit) begin
			// R5 msb first assembly
			unique case (byte_idx)
				2'd0: begin
					next_hold     = {8'h00, acc.data};
					next_byte_idx = 2'd1;
				end
				2'd1: begin
					next_hold     = {hold[7:0], acc.data};
					next_byte_idx = 2'd2;
				end
				default: begin
					wr.en         = 1'b1;
					next_byte_idx = 2'd0;
					// R16 advance after store
					// R4 ascending locations
					if (ptr != MDR_ADDR_W'(MDR_MEM_DEPTH - 1)) begin
						next_ptr = ptr + 1'b1;
					end
				end
			endcase
		end else if (state == MDR_LOAD && abort_hit) begin
			// R8 abort resets pointer
			next_ptr      = MDR_PTR_RESET;
			next_byte_idx = 2'd0;
		end
	end

	// assembly and pointer registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ptr      <= MDR_PTR_RESET;
			byte_idx <= 2'd0;
			hold     <= 16'h0000;
		end else begin
			ptr      <= next_ptr;
			byte_idx <= next_byte_idx;
			hold     <= next_hold;
		end
	end

	// next values of the restart timer and the ready flag
	always_comb begin
		next_cnt       = cnt;
		next_serial_rs = serial_rs;
		next_irq       = irq;
		if (state == MDR_LOAD && restart_hit) begin
			// R9 start init timer
			next_cnt       = MDR_CNT_W'(INIT_CYCLES - 1);
			next_serial_rs = restart_via_serial;
			next_irq       = 1'b0;
		end else if (init_done) begin
			// R15 raise ready flag
			next_serial_rs = 1'b0;
			next_irq       = 1'b1;
		end else if (state == MDR_INIT) begin
			// R10 count down
			next_cnt = cnt - 1'b1;
		end else if (state == MDR_RUN && acc.valid) begin
			// set only in init, so set and clear never meet
			next_irq = 1'b0;
		end
	end

	// timer and flag registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt       <= '0;
			serial_rs <= 1'b0;
			irq       <= 1'b0;
		end else begin
			cnt       <= next_cnt;
			serial_rs <= next_serial_rs;
			irq       <= next_irq;
		end
	end

	// R11 5k by 20 memory
	mdr_imem u_imem (
		.clk     (clk),
		.wr      (wr),
		.rd_addr (cpu_fetch_addr),
		.rd_data (cpu_fetch_data)
	);

	// status towards the processor and the host ports
	assign cpu_halt               = (state == MDR_LOAD);
	assign init_busy              = (state == MDR_INIT);
	// R13 serial clock stretch
	assign serial_clk_hold_low    = (state == MDR_INIT) && serial_rs;
	// R14 slave terminate
	assign vip_terminate          = (state == MDR_INIT);
	// R15 ready indication
	assign host_interrupt_request = irq;
	assign load_pointer           = ptr;
endmodule

// ---- verification/mdr_loader_asserts.sv ----
// port assertions for the microcode loader
`timescale 1ns/1ps
module mdr_chk
	import mdr_pkg::*;
(
	input wire logic                  clk,
	input wire logic                  rst,
	input wire mdr_access_t           acc,
	input wire logic                  restart_via_serial,
	input wire logic                  cpu_halt,
	input wire logic                  init_busy,
	input wire logic                  serial_clk_hold_low,
	input wire logic                  vip_terminate,
	input wire logic [MDR_ADDR_W-1:0] load_pointer
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// a write access to one address
	sequence wr_s(a);
		acc.valid && acc.write && acc.addr == a;
	endsequence
	halt_load_a: assert property (
		wr_s(8'h7E) ##0 !init_busy |=> cpu_halt) else $error("no halt");
	abort_zero_a: assert property (
		cpu_halt && acc.valid && acc.addr[7:1] != 7'h3F
		|=> !cpu_halt && load_pointer == '0) else $error("no abort");
	restart_wake_a: assert property (
		cpu_halt ##0 wr_s(8'h7F) |=> !cpu_halt && init_busy)
		else $error("no wake");
	pointer_step_a: assert property (
		!$stable(load_pointer) |-> load_pointer == '0
		|| load_pointer == $past(load_pointer) + 1) else $error("bad step");
	mem_depth_a: assert property (
		load_pointer <= 13'h13FF) else $error("pointer past end");
	serial_hold_a: assert property (
		$rose(init_busy) |-> serial_clk_hold_low == $past(restart_via_serial))
		else $error("bad clock hold");
	vip_term_a: assert property (
		vip_terminate == init_busy) else $error("bad terminate");
	init_wait_a: assert property (
		$rose(init_busy) |-> init_busy[*8]) else $error("short init");
endmodule
bind mdr_loader mdr_chk chk (
	.clk                 (clk),
	.rst                 (rst),
	.acc                 (acc),
	.restart_via_serial  (restart_via_serial),
	.cpu_halt            (cpu_halt),
	.init_busy           (init_busy),
	.serial_clk_hold_low (serial_clk_hold_low),
	.vip_terminate       (vip_terminate),
	.load_pointer        (load_pointer)
);

// ---- verification/mdr_host.sv ----
// host controller model issuing register accesses
`timescale 1ns/1ps
module mdr_host
	import mdr_pkg::*;
(
	input wire logic clk,
	output mdr_access_t acc
);
	initial acc = '0;
	// access held across one edge, entered just after an edge
	task xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
		acc = {1'b1, w, a, d};
		@(posedge clk);
		#1;
	endtask
	// released data flips so a stale byte never looks valid
	task idle(input int n);
		acc = {1'b0, acc.write, acc.addr, ~acc.data};
		repeat (n) begin
			@(posedge clk);
			#1;
		end
	endtask
	task word(input logic [19:0] w);
		xfer(1'b1, 8'h7E, {4'hA, w[19:16]});
		xfer(1'b1, 8'h7E, w[15:8]);
		xfer(1'b1, 8'h7E, w[7:0]);
	endtask
endmodule

// ---- verification/microcode_download_restart_test.sv ----
// self-checking bench for the microcode loader
`timescale 1ns/1ps
module microcode_download_restart_test;
	import mdr_pkg::*;
	logic        clk = 0;
	logic        rst = 1;
	logic        restart_via_serial = 0;
	logic [12:0] cpu_fetch_addr = '0;
	logic [19:0] cpu_fetch_data;
	logic        cpu_halt, init_busy, serial_clk_hold_low, vip_terminate;
	logic        host_interrupt_request;
	logic [12:0] load_pointer;
	mdr_access_t acc;
	int          err_total = 0;
	int          check_count = 0;
	int          cyc = 0;
	// short init wait so that restarts fit the run
	localparam int INIT_SIM = 20;
	always #20 clk = ~clk;
	mdr_host host (
		.clk (clk),
		.acc (acc)
	);
	mdr_loader #(.INIT_CYCLES(INIT_SIM)) dut (
		.clk                    (clk),
		.rst                    (rst),
		.acc                    (acc),
		.restart_via_serial     (restart_via_serial),
		.cpu_fetch_addr         (cpu_fetch_addr),
		.cpu_fetch_data         (cpu_fetch_data),
		.cpu_halt               (cpu_halt),
		.init_busy              (init_busy),
		.serial_clk_hold_low    (serial_clk_hold_low),
		.vip_terminate          (vip_terminate),
		.host_interrupt_request (host_interrupt_request),
		.load_pointer           (load_pointer)
	);
	task chk(input logic [19:0] s, input logic [19:0] e);
		check_count++;
		if (s !== e) begin
			err_total++;
			$display("BAD %0t got %h want %h", $time, s, e);
		end
	endtask
	task conclude;
		if (err_total == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// restart, then wait out the init
	task restart(input logic s);
		restart_via_serial = s;
		host.xfer(1'b1, MDR_RESTART_OFFSET, 8'h00);
		host.xfer(1'b1, MDR_LOAD_OFFSET, 8'h00);
		chk(init_busy, 1'b1);
		chk(cpu_halt, 1'b0);
		chk(serial_clk_hold_low, s);
		chk(vip_terminate, 1'b1);
		host.idle(INIT_SIM - 2);
		chk(init_busy, 1'b1);
		host.idle(1);
		chk(init_busy, 1'b0);
		chk(host_interrupt_request, 1'b1);
		// next host access drops the ready flag
		host.xfer(1'b0, 8'h20, 8'h00);
		chk(host_interrupt_request, 1'b0);
	endtask
	task fetch(input logic [12:0] a, input logic [19:0] e);
		cpu_fetch_addr = a;
		host.idle(2);
		chk(cpu_fetch_data, e);
	endtask
	// hang guard, well above the longest load
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			err_total++;
			conclude;
		end
	end
	initial begin
		repeat (10) @(posedge clk);
		#1 rst = 0;
		host.idle(12);
		host.word(20'h12345);
		host.word(20'hFEDCB);
		host.idle(1);
		chk(load_pointer, 2);
		chk(cpu_halt, 1'b1);
		host.xfer(1'b1, 8'h7E, 8'hF5);
		host.xfer(1'b1, 8'h7E, 8'h55);
		host.idle(3);
		chk(load_pointer, 2);
		host.xfer(1'b1, 8'h7E, 8'h66);
		host.idle(1);
		chk(load_pointer, 3);
		restart(1'b1);
		fetch(13'h0000, 20'h12345);
		fetch(13'h0002, 20'h55566);
		host.word(20'h0ABCD);
		host.xfer(1'b0, 8'h20, 8'h00);
		host.idle(1);
		chk(load_pointer, 0);
		chk(cpu_halt, 1'b0);
		host.word(20'h77777);
		restart(1'b0);
		fetch(13'h0000, 20'h77777);
		// one word past the end lands on the last word
		for (logic [19:0] i = 0; i < 20'h01401; i++)
			host.word(i);
		host.idle(1);
		chk(load_pointer, 13'h13FF);
		restart(1'b0);
		fetch(13'h13FF, 20'h01400);
		host.word(20'h11111);
		rst = 1'b1;
		host.idle(3);
		rst = 1'b0;
		chk(cpu_halt, 1'b0);
		chk(load_pointer, 0);
		host.idle(5);
		host.word(20'h4B1D2);
		restart(1'b1);
		fetch(13'h0000, 20'h4B1D2);
		conclude;
	end
endmodule
